//--- src/sos_top.sv
// status output select: relay and open collector 1 condition selection
`timescale 1ns/1ps
module sos_top #(
    parameter int          FREQ_W   = sos_pkg::FREQ_W,
    parameter int          CUR_W    = sos_pkg::CUR_W,
    parameter int          STEP_CYC = sos_pkg::DLY_STEP_CYC,
    parameter int          OFF_CYC  = sos_pkg::OFF_DELAY_CYC,
    parameter int          PWM_CYC  = sos_pkg::PWM_PERIOD_CYC
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // drive state
    input  wire logic              run_cmd_i,
    input  wire logic              output_active_i,
    input  wire logic              reverse_i,
    input  wire logic [FREQ_W-1:0] out_freq_i,
    input  wire logic [FREQ_W-1:0] cmd_freq_i,
    input  wire logic [FREQ_W-1:0] max_freq_i,
    input  wire logic [CUR_W-1:0]  out_cur_i,
    input  wire logic [CUR_W-1:0]  full_cur_i,
    input  wire logic              overload_i,
    input  wire logic              thermal_i,
    input  wire logic              fault_i,
    input  wire logic              timer_cycle_wait_i,
    input  wire logic              timer_end_indication_i,
    input  wire logic              alarm_flash_i,
    input  wire logic              speed_search_i,
    // settings
    input  wire logic [3:0]        relay_function_select_i,
    input  wire logic              relay_non_energizing_i,
    input  wire logic [3:0]        open_collector1_function_select_i,
    input  wire logic [FREQ_W-1:0] open_collector_freq_threshold_i,
    input  wire logic [FREQ_W-1:0] relay_freq_threshold_i,
    input  wire logic [CUR_W-1:0]  current_threshold_level_i,
    input  wire logic [6:0]        current_detect_on_delay_i,
    input  wire logic              status_output_source_select_i,
    // outputs
    output logic                   relay_output_o,
    output logic                   open_collector_output_one_o
);
    logic [FREQ_W-1:0] freq_diff;
    logic              arrival;
    logic              freq_det_relay;
    logic              freq_det_oc;
    logic [CUR_W-1:0]  cur_thr;
    logic              cur_above_raw;
    logic              cur_below_raw;
    logic              cur_above;
    logic              cur_below;
    logic              stopped;
    logic [31:0]       pwm_on_cyc;
    logic              pwm_wave;
    logic              relay_cond;
    logic              oc_cond;
    logic              nxt_relay;
    logic              nxt_oc;
    logic              relay_ff;
    logic              oc_ff;

    //////////////////////////////////////////////////////////////////////
    // clamp a frequency threshold into the settable range; 0 stays 0
    function automatic logic [FREQ_W-1:0] clamp_freq(input logic [FREQ_W-1:0] v);
        clamp_freq = (v > FREQ_W'(sos_pkg::FREQ_THR_MAX)) ? FREQ_W'(sos_pkg::FREQ_THR_MAX) : v;
    endfunction : clamp_freq

    // select a condition by code; pwm code only for output 1
    function automatic logic cond_sel(input logic [3:0] code, input logic allow_pwm, input logic fdet);
        cond_sel = 1'b0;
        unique case (code)
            sos_pkg::SEL_RUN:      cond_sel = run_cmd_i | output_active_i;
            sos_pkg::SEL_REVERSE:  cond_sel = reverse_i;
            sos_pkg::SEL_ARRIVAL:  cond_sel = arrival;
            sos_pkg::SEL_OVERLOAD: cond_sel = overload_i | thermal_i;
            sos_pkg::SEL_FREQ_DET: cond_sel = fdet;
            sos_pkg::SEL_CUR_ABV:  cond_sel = cur_above;
            sos_pkg::SEL_CUR_BLW:  cond_sel = cur_below;
            sos_pkg::SEL_FAULT:    cond_sel = fault_i;
            sos_pkg::SEL_NORMAL:   cond_sel = ~fault_i;
            sos_pkg::SEL_CYCLE:    cond_sel = timer_cycle_wait_i;
            sos_pkg::SEL_TMR_END:  cond_sel = timer_end_indication_i;
            sos_pkg::SEL_ALARM:    cond_sel = alarm_flash_i;
            sos_pkg::SEL_SEARCH:   cond_sel = speed_search_i;
            sos_pkg::SEL_PWM:      cond_sel = allow_pwm & pwm_wave;
            default:               cond_sel = 1'b0;
        endcase
    endfunction : cond_sel

    //////////////////////////////////////////////////////////////////////
    // frequency arrival and threshold detection
    always_comb begin
        freq_diff      = (out_freq_i > cmd_freq_i) ? out_freq_i - cmd_freq_i : cmd_freq_i - out_freq_i;
        arrival        = (freq_diff <= FREQ_W'(sos_pkg::ARRIVAL_BAND));
        freq_det_relay = (out_freq_i > clamp_freq(relay_freq_threshold_i));
        freq_det_oc    = (out_freq_i > clamp_freq(open_collector_freq_threshold_i));
    end

    // current threshold clamp and raw comparisons
    always_comb begin
        cur_thr = current_threshold_level_i;
        if (cur_thr < CUR_W'(sos_pkg::CUR_THR_MIN)) begin
            cur_thr = CUR_W'(sos_pkg::CUR_THR_MIN);
        end else if (cur_thr > CUR_W'(sos_pkg::CUR_THR_MAX)) begin
            cur_thr = CUR_W'(sos_pkg::CUR_THR_MAX);
        end
        cur_above_raw = (out_cur_i > cur_thr);
        cur_below_raw = (out_cur_i < cur_thr);
    end

    //////////////////////////////////////////////////////////////////////
    // delayed current sensing signals
    sos_cur_delay #(
        .STEP_CYC   (STEP_CYC),
        .OFF_CYC    (OFF_CYC)
    ) u_dly_above (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .raw_i      (cur_above_raw),
        .on_delay_i (current_detect_on_delay_i),
        .det_o      (cur_above)
    );

    sos_cur_delay #(
        .STEP_CYC   (STEP_CYC),
        .OFF_CYC    (OFF_CYC)
    ) u_dly_below (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .raw_i      (cur_below_raw),
        .on_delay_i (current_detect_on_delay_i),
        .det_o      (cur_below)
    );

    //////////////////////////////////////////////////////////////////////
    // pwm on time: quantity over full scale times period, saturated
    always_comb begin
        stopped    = ~(run_cmd_i | output_active_i);
        pwm_on_cyc = '0;
        if (!status_output_source_select_i) begin
            if (max_freq_i != '0) begin
                pwm_on_cyc = 32'((64'(out_freq_i) * 64'(PWM_CYC)) / 64'(max_freq_i));
            end
        end else if (!stopped && full_cur_i != '0) begin
            pwm_on_cyc = 32'((64'(out_cur_i) * 64'(PWM_CYC)) / 64'(full_cur_i));
        end
        if (pwm_on_cyc > 32'(PWM_CYC)) begin
            pwm_on_cyc = 32'(PWM_CYC);
        end
    end

    sos_pwm #(
        .PERIOD_CYC (PWM_CYC)
    ) u_pwm (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .on_cyc_i   (pwm_on_cyc),
        .pwm_o      (pwm_wave)
    );

    //////////////////////////////////////////////////////////////////////
    // output selection and relay coil polarity
    always_comb begin
        relay_cond = cond_sel(relay_function_select_i, 1'b0, freq_det_relay);
        oc_cond    = cond_sel(open_collector1_function_select_i, 1'b1, freq_det_oc);
        nxt_relay  = relay_non_energizing_i ? ~relay_cond
                                            : relay_cond;
        nxt_oc     = oc_cond;
    end

    // output registers; coil off during reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            relay_ff <= 1'b0;
            oc_ff    <= 1'b0;
        end else begin
            relay_ff <= nxt_relay;
            oc_ff    <= nxt_oc;
        end
    end

    assign relay_output_o              = relay_ff; // high = coil energized
    assign open_collector_output_one_o = oc_ff;    // high = transistor on
endmodule : sos_top

//--- src/sos_pkg.sv
// package with constants for the status output select block
package sos_pkg;
    // function select codes
    localparam logic [3:0] SEL_RUN      = 4'h0;
    localparam logic [3:0] SEL_REVERSE  = 4'h1;
    localparam logic [3:0] SEL_ARRIVAL  = 4'h2;
    localparam logic [3:0] SEL_OVERLOAD = 4'h3;
    localparam logic [3:0] SEL_FREQ_DET = 4'h4;
    localparam logic [3:0] SEL_CUR_ABV  = 4'h5;
    localparam logic [3:0] SEL_CUR_BLW  = 4'h6;
    localparam logic [3:0] SEL_FAULT    = 4'h7;
    localparam logic [3:0] SEL_NORMAL   = 4'h8;
    localparam logic [3:0] SEL_CYCLE    = 4'h9;
    localparam logic [3:0] SEL_TMR_END  = 4'hA;
    localparam logic [3:0] SEL_ALARM    = 4'hB;
    localparam logic [3:0] SEL_SEARCH   = 4'hC;
    localparam logic [3:0] SEL_PWM      = 4'hD;
    // widths: frequency in 0.1 Hz, current in 0.1 A
    localparam int FREQ_W = 12;
    localparam int CUR_W  = 10;
    // arrival window 2 Hz in 0.1 Hz units
    localparam logic [11:0] ARRIVAL_BAND = 12'h014;
    // limits of settable thresholds
    localparam logic [11:0] FREQ_THR_MAX = 12'hFA0; // 400.0 Hz
    localparam logic [9:0]  CUR_THR_MIN  = 10'h001; // 0.1 A
    localparam logic [9:0]  CUR_THR_MAX  = 10'h3E8; // 100.0 A
    localparam logic [6:0]  DLY_MIN      = 7'h01;   // 0.1 s
    localparam logic [6:0]  DLY_MAX      = 7'h64;   // 10.0 s
    // timing
    localparam int CLK_HZ       = 100_000_000;
    localparam int OFF_DELAY_MS = 100;
    localparam int PWM_PERIOD_US = 1000;
    localparam int DLY_STEP_MS  = 100;
    localparam int OFF_DELAY_CYC = CLK_HZ / 1000 * OFF_DELAY_MS;
    localparam int PWM_PERIOD_CYC = CLK_HZ / 1_000_000 * PWM_PERIOD_US;
    localparam int DLY_STEP_CYC = CLK_HZ / 1000 * DLY_STEP_MS;
    localparam int CNT_W = 32;
endpackage : sos_pkg

//--- src/sos_cur_delay.sv
// current sensing delay filter with programmable on delay and fixed off delay
`timescale 1ns/1ps
module sos_cur_delay #(
    parameter int STEP_CYC = sos_pkg::DLY_STEP_CYC,
    parameter int OFF_CYC  = sos_pkg::OFF_DELAY_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       raw_i,
    input  wire logic [6:0] on_delay_i,
    output logic            det_o
);
    localparam logic [31:0] STEP_LAST = 32'(STEP_CYC - 1);
    localparam logic [31:0] OFF_LAST  = 32'(OFF_CYC - 1);

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic [6:0]  step_ff;
    logic [6:0]  nxt_step;
    logic        det_ff;
    logic        nxt_det;
    logic [6:0]  dly;

    //////////////////////////////////////////////////////////////////////
    // next state: count toward the change while raw differs from output
    always_comb begin
        dly      = on_delay_i;
        nxt_cnt  = cnt_ff;
        nxt_step = step_ff;
        nxt_det  = det_ff;
        if (dly < sos_pkg::DLY_MIN) begin
            dly = sos_pkg::DLY_MIN;
        end else if (dly > sos_pkg::DLY_MAX) begin
            dly = sos_pkg::DLY_MAX;
        end
        if (raw_i == det_ff) begin
            nxt_cnt  = '0;
            nxt_step = '0;
        end else if (!det_ff) begin
            // off to on waits the programmed tenths of seconds
            if (cnt_ff == STEP_LAST) begin
                nxt_cnt  = '0;
                nxt_step = step_ff + 7'h01;
                if (step_ff + 7'h01 >= dly) begin
                    nxt_det  = 1'b1;
                    nxt_step = '0;
                end
            end else begin
                nxt_cnt = cnt_ff + 32'h1;
            end
        end else begin
            // on to off after the fixed delay
            if (cnt_ff == OFF_LAST) begin
                nxt_cnt = '0;
                nxt_det = 1'b0;
            end else begin
                nxt_cnt = cnt_ff + 32'h1;
            end
        end
    end

    // registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            step_ff <= '0;
            det_ff  <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            step_ff <= nxt_step;
            det_ff  <= nxt_det;
        end
    end

    assign det_o = det_ff;
endmodule : sos_cur_delay

//--- src/sos_pwm.sv
// 1 ms status pwm generator with duty proportional to a level
`timescale 1ns/1ps
module sos_pwm #(
    parameter int PERIOD_CYC = sos_pkg::PWM_PERIOD_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] on_cyc_i,
    output logic             pwm_o
);
    localparam logic [31:0] LAST = 32'(PERIOD_CYC - 1);

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic [31:0] duty_ff;
    logic [31:0] nxt_duty;
    logic        pwm_ff;
    logic        nxt_pwm;

    //////////////////////////////////////////////////////////////////////
    // period counter, duty latched at period start to avoid glitches
    always_comb begin
        nxt_cnt  = (cnt_ff == LAST) ? '0 : cnt_ff + 32'h1;
        nxt_duty = (cnt_ff == LAST) ? on_cyc_i : duty_ff;
        nxt_pwm  = (nxt_cnt < nxt_duty);
    end

    // registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            duty_ff <= '0;
            pwm_ff  <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            duty_ff <= nxt_duty;
            pwm_ff  <= nxt_pwm;
        end
    end

    assign pwm_o = pwm_ff;
endmodule : sos_pwm

//--- dv/sos_top_properties.sv
// assertion checker for the status output select block
`timescale 1ns/1ps
module sos_top_properties #(
    parameter int FREQ_W = 12,
    parameter int CUR_W  = 10
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              run_cmd_i,
    input wire logic              output_active_i,
    input wire logic              reverse_i,
    input wire logic [FREQ_W-1:0] out_freq_i,
    input wire logic [FREQ_W-1:0] cmd_freq_i,
    input wire logic [CUR_W-1:0]  out_cur_i,
    input wire logic              overload_i,
    input wire logic              thermal_i,
    input wire logic              fault_i,
    input wire logic              timer_cycle_wait_i,
    input wire logic              timer_end_indication_i,
    input wire logic              alarm_flash_i,
    input wire logic              speed_search_i,
    input wire logic [3:0]        relay_function_select_i,
    input wire logic              relay_non_energizing_i,
    input wire logic [FREQ_W-1:0] relay_freq_threshold_i,
    input wire logic [CUR_W-1:0]  current_threshold_level_i,
    input wire logic              relay_output_o
);
    logic [FREQ_W-1:0] f_gap;
    logic              cur_above;
    logic              tmr_cond;
    logic              pos;
    // helper compares taken from the inputs only
    assign f_gap = (out_freq_i >= cmd_freq_i) ? out_freq_i - cmd_freq_i : cmd_freq_i - out_freq_i;
    assign cur_above = out_cur_i > current_threshold_level_i;
    assign pos = !relay_non_energizing_i;
    assign tmr_cond = (relay_function_select_i == 4'h9) ? timer_cycle_wait_i :
                      (relay_function_select_i == 4'hA) ? timer_end_indication_i :
                      (relay_function_select_i == 4'hB) ? alarm_flash_i : speed_search_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // raw above-threshold compare starting after a quiet stretch
    sequence s_cur_start;
        relay_function_select_i == 4'h5 && pos && !cur_above && !$past(cur_above) && !relay_output_o
        ##1 relay_function_select_i == 4'h5 && cur_above;
    endsequence
    sequence s_cur_hold_low;
        (!relay_output_o || relay_function_select_i != 4'h5) [*8];
    endsequence
    property p_run;
        relay_function_select_i == 4'h0 && pos |=> relay_output_o == $past(run_cmd_i | output_active_i);
    endproperty
    property p_rev_inverted;
        relay_function_select_i == 4'h1 && !pos |=> relay_output_o == !$past(reverse_i);
    endproperty
    property p_arrival;
        relay_function_select_i == 4'h2 && pos |=> relay_output_o == $past(f_gap <= 12'h014);
    endproperty
    property p_overload;
        relay_function_select_i == 4'h3 && pos |=> relay_output_o == $past(overload_i | thermal_i);
    endproperty
    property p_freq_det;
        relay_function_select_i == 4'h4 && pos && relay_freq_threshold_i <= 12'hFA0
        |=> relay_output_o == $past(out_freq_i > relay_freq_threshold_i);
    endproperty
    property p_fault;
        (relay_function_select_i == 4'h7 || relay_function_select_i == 4'h8) && pos
        |=> relay_output_o == $past(fault_i ^ (relay_function_select_i == 4'h8));
    endproperty
    property p_timer_alarm_search;
        relay_function_select_i >= 4'h9 && relay_function_select_i <= 4'hC && pos |=> relay_output_o == $past(tmr_cond);
    endproperty
    property p_cur_on_delay;
        s_cur_start |-> s_cur_hold_low;
    endproperty
    property p_relay_no_pwm;
        relay_function_select_i >= 4'hD && pos |=> !relay_output_o;
    endproperty
    a_run: assert property (p_run) else $error("relay run selection wrong");
    a_rev_inverted: assert property (p_rev_inverted) else $error("relay inverted reverse wrong");
    a_arrival: assert property (p_arrival) else $error("relay arrival wrong");
    a_overload: assert property (p_overload) else $error("relay overload wrong");
    a_freq_det: assert property (p_freq_det) else $error("relay frequency sensing wrong");
    a_fault: assert property (p_fault) else $error("relay fault selection wrong");
    a_timer_alarm_search: assert property (p_timer_alarm_search) else $error("relay event wrong");
    a_cur_on_delay: assert property (p_cur_on_delay) else $error("current sensing rose early");
    a_relay_no_pwm: assert property (p_relay_no_pwm) else $error("relay on for unused code");
endmodule : sos_top_properties
bind sos_top sos_top_properties #(.FREQ_W(FREQ_W), .CUR_W(CUR_W)) sos_top_properties_inst (.sys_clk_i, .rst_i,
    .run_cmd_i, .output_active_i, .reverse_i, .out_freq_i, .cmd_freq_i, .out_cur_i, .overload_i, .thermal_i,
    .fault_i, .timer_cycle_wait_i, .timer_end_indication_i, .alarm_flash_i, .speed_search_i,
    .relay_function_select_i, .relay_non_energizing_i, .relay_freq_threshold_i, .current_threshold_level_i,
    .relay_output_o);

//--- dv/sos_load.sv
// far side load that sums the on time of open collector output one
`timescale 1ns/1ps
module sos_load #(
    parameter int PERIOD = 100
) (
    input  wire logic sys_clk_i,
    input  wire logic oc_i,
    output int        high_cnt_o
);
    int win_ff = 0;
    int acc_ff = 0;
    // high cycles summed over windows one period long
    always_ff @(posedge sys_clk_i) begin
        win_ff <= (win_ff >= PERIOD - 1) ? 0 : win_ff + 1;
        acc_ff <= (win_ff >= PERIOD - 1) ? 0 : acc_ff + int'(oc_i === 1'b1);
        if (win_ff >= PERIOD - 1) high_cnt_o <= acc_ff + int'(oc_i === 1'b1);
    end
endmodule : sos_load

//--- dv/sos_top_test.sv
// self checking bench for the status output select block
`timescale 1ns/1ps
module sos_top_test;
    localparam int STEP = 20;
    localparam int OFFC = 50;
    localparam int PWMC = 100;
    logic sys_clk_i = 0, rst_i = 1, run_cmd_i = 0, output_active_i = 0, reverse_i = 0, overload_i = 0;
    logic thermal_i = 0, fault_i = 0, timer_cycle_wait_i = 0, timer_end_indication_i = 0, alarm_flash_i = 0;
    logic speed_search_i = 0, relay_non_energizing_i = 0, status_output_source_select_i = 0;
    logic [11:0] out_freq_i = 0, cmd_freq_i = 12'h3E8, max_freq_i = 12'hFA0;
    logic [11:0] open_collector_freq_threshold_i = 12'h3E8, relay_freq_threshold_i = 12'h3E8;
    logic [9:0]  out_cur_i = 0, full_cur_i = 10'h3E8, current_threshold_level_i = 10'h3E8;
    logic [6:0]  current_detect_on_delay_i = 7'h01;
    logic [3:0]  relay_function_select_i = 0, open_collector1_function_select_i = 0;
    logic        relay_output_o, open_collector_output_one_o;
    int          high_cnt, mismatches = 0, samples_checked = 0, cycles = 0;
    logic        e;
    sos_top #(.STEP_CYC(STEP), .OFF_CYC(OFFC), .PWM_CYC(PWMC)) sos_top_inst (.sys_clk_i, .rst_i, .run_cmd_i,
        .output_active_i, .reverse_i, .out_freq_i, .cmd_freq_i, .max_freq_i, .out_cur_i, .full_cur_i,
        .overload_i, .thermal_i, .fault_i, .timer_cycle_wait_i, .timer_end_indication_i, .alarm_flash_i,
        .speed_search_i, .relay_function_select_i, .relay_non_energizing_i, .open_collector1_function_select_i,
        .open_collector_freq_threshold_i, .relay_freq_threshold_i, .current_threshold_level_i,
        .current_detect_on_delay_i, .status_output_source_select_i, .relay_output_o, .open_collector_output_one_o);
    sos_load #(.PERIOD(PWMC)) sos_load_inst (.sys_clk_i, .oc_i(open_collector_output_one_o), .high_cnt_o(high_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    always #5 sys_clk_i = ~sys_clk_i;
    // hang guard
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // inputs change one ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick
    // the selected code sees v, other driven conditions its inverse; frequency detection always sees the inverse of arrival
    task automatic set_cond(input logic [3:0] c, input logic v);
        run_cmd_i = (c == 4'h0) ? v : !v;
        reverse_i = (c == 4'h1) ? v : !v;
        overload_i = (c == 4'h3) ? v : !v;
        fault_i = (c == 4'h7) ? v : !v;
        timer_cycle_wait_i = (c == 4'h9) ? v : !v;
        timer_end_indication_i = (c == 4'hA) ? v : !v;
        alarm_flash_i = (c == 4'hB) ? v : !v;
        speed_search_i = (c == 4'hC) ? v : !v;
        out_freq_i = ((c == 4'h2) == v) ? cmd_freq_i - 12'h014 : cmd_freq_i + 12'h015;
    endtask : set_cond
    task automatic wait_relay(input logic lvl, input int exp);
        int n;
        n = 0;
        while (relay_output_o !== lvl && n < 500) begin
            tick(1);
            n++;
        end
        check("relay delay", n, exp);
    endtask : wait_relay
    task automatic pwm_case(input logic [3:0] sel, input logic src, input logic run, input logic act,
                            input logic [11:0] f, input logic [9:0] cur, input int exp);
        open_collector1_function_select_i = sel;
        status_output_source_select_i = src;
        run_cmd_i = run;
        output_active_i = act;
        out_freq_i = f;
        out_cur_i = cur;
        tick(4 * PWMC); // one period to latch, one to settle, full window after
        check("pwm on time", high_cnt, exp);
    endtask : pwm_case
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        rst_i = 0;
        // every relay code except the current codes 5 and 6 in both polarities, unused codes included
        for (int p = 0; p < 2; p++) for (int c = 0; c < 16; c++) for (int v = 0; v < 2; v++) begin
            if (c == 5 || c == 6) continue;
            relay_non_energizing_i = p[0];
            relay_function_select_i = c[3:0];
            set_cond(c[3:0], v[0]);
            e = (c < 13) && v[0]; // set_cond already drives fault low for code 8 when v is set
            tick(2);
            check("relay level", {31'h0, relay_output_o}, {31'h0, e ^ p[0]});
        end
        relay_non_energizing_i = 0;
        relay_function_select_i = 4'h3;
        set_cond(4'h3, 1'b0);
        thermal_i = 1;
        tick(2);
        check("thermal relay", {31'h0, relay_output_o}, 32'h1);
        thermal_i = 0;
        relay_function_select_i = 4'h4;
        open_collector1_function_select_i = 4'h4;
        relay_freq_threshold_i = 12'h000;
        open_collector_freq_threshold_i = 12'hFA0;
        out_freq_i = 12'h001;
        tick(2);
        check("relay zero threshold", {31'h0, relay_output_o}, 32'h1);
        check("oc top threshold", {31'h0, open_collector_output_one_o}, 32'h0);
        $display("selection test done");
        // current sensing with on delay, fixed off delay and a restart
        relay_function_select_i = 4'h5;
        out_cur_i = 10'h3E8;
        tick(80);
        check("equal current", {31'h0, relay_output_o}, 32'h0);
        out_cur_i = 10'h3E9;
        wait_relay(1'b1, STEP + 1);
        out_cur_i = 10'h3E8;
        wait_relay(1'b0, OFFC + 1);
        current_detect_on_delay_i = 7'h03;
        out_cur_i = 10'h3E9;
        tick(30);
        out_cur_i = 10'h3E8;
        tick(1);
        out_cur_i = 10'h3E9;
        wait_relay(1'b1, 3 * STEP + 1);
        relay_function_select_i = 4'h6;
        relay_non_energizing_i = 1;
        tick(80);
        check("below idle", {31'h0, relay_output_o}, 32'h1);
        out_cur_i = 10'h3E7;
        wait_relay(1'b0, 3 * STEP + 1);
        $display("current test done");
        // status pwm on open collector one
        relay_non_energizing_i = 0;
        relay_function_select_i = 4'h0;
        pwm_case(4'hD, 1'b0, 1'b0, 1'b0, 12'h3E8, 10'h000, 25);
        pwm_case(4'hD, 1'b0, 1'b1, 1'b1, 12'hFA0, 10'h000, PWMC);
        pwm_case(4'hD, 1'b1, 1'b1, 1'b0, 12'h3E8, 10'h12C, 30);
        pwm_case(4'hD, 1'b1, 1'b0, 1'b0, 12'h3E8, 10'h12C, 0);
        pwm_case(4'hD, 1'b1, 1'b0, 1'b1, 12'h3E8, 10'h12C, 30);
        pwm_case(4'h0, 1'b0, 1'b0, 1'b0, 12'h3E8, 10'h12C, 0);
        $display("pwm test done");
        end_sim();
    end
endmodule : sos_top_test
